// ===== hw/cmg_pkg.sv
// Package for the comparator event and mask gating block
package cmg_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam int CTRL_AMP_EN = 10;
  localparam int CTRL_EVT = 9;
  localparam int CTRL_OUT = 8;
  localparam int CTRL_EDGE_HI = 7;
  localparam int CTRL_EDGE_LO = 6;
  localparam int CTRL_POS_SEL = 4;
  localparam int CTRL_NEG_HI = 1;
  localparam int CTRL_NEG_LO = 0;
  localparam int CTRL_INV = 13;
  localparam logic [15:0] CTRL_WMASK = 16'h24D3;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [3:0] gate;
    logic [1:0] stat;
    logic [1:0] irq_mask;
    logic evt;
    logic cmp_prev;
    logic [15:0] rdata;
    logic [3:0] neg_sel;
    logic pos_ref;
    logic amp_en;
    logic and_out;
    logic irq;
  } cmg_state_t;
endpackage

// ===== hw/cmg_core.sv
// Comparator event, input select and mask AND gate logic
// Functional notes
// - Edge select 11: event on any change of the comparator result.
// - Edge select 10: event on falling edge of polarity-adjusted result.
// - Edge select 01: event on rising edge of polarity-adjusted result.
// - New events only while the latched event flag is clear.
// - Edge select 00: no event from the comparator result.
// - Positive select set routes to internal reference, else first pin.
// - Negative select picks one of four inverting pins by code.
// - Control bit 5 and bits 3 to 2 read as zero.
// - Amplifier enable only enables the amplifier; comparator keeps working.
// - Gate B true enable adds mask input B to the AND gate.
// - Gate B inverted enable adds inverted mask input B.
// - Gate A true enable adds mask input A to the AND gate.
// - Gate A inverted enable adds inverted mask input A.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module cmg_core (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_comparator_result,
  input wire logic i_mask_input_a,
  input wire logic i_mask_input_b,
  output logic [15:0] o_rdata,
  output logic [3:0] o_negative_input_select,
  output logic o_positive_input_select,
  output logic o_amplifier_enable,
  output logic o_and_gate_out,
  output logic o_event_pulse_level,
  output logic o_irq
);
  cmg_pkg::cmg_state_t st_reg, st_next;
  logic adj_now, adj_prev, edge_hit;

  // Edge qualification against the selected mode
  function automatic logic edge_ok(input logic [1:0] sel, input logic now,
                                   input logic prev);
    unique case (sel)
      cmg_pkg::EDGE_ANY: edge_ok = now ^ prev;
      cmg_pkg::EDGE_FALL: edge_ok = prev & ~now;
      cmg_pkg::EDGE_RISE: edge_ok = ~prev & now;
      cmg_pkg::EDGE_NONE: edge_ok = 1'b0;
    endcase
  endfunction

  always_comb begin
    st_next = st_reg;
    adj_now = i_comparator_result ^ st_reg.ctrl[cmg_pkg::CTRL_INV];
    adj_prev = st_reg.cmp_prev ^ st_reg.ctrl[cmg_pkg::CTRL_INV];
    edge_hit = edge_ok(st_reg.ctrl[cmg_pkg::CTRL_EDGE_HI:cmg_pkg::CTRL_EDGE_LO],
                       adj_now, adj_prev) & ~st_reg.evt;
    st_next.cmp_prev = i_comparator_result;
    st_next.rdata = 16'h0000;
    if (i_rd) begin
      unique case (i_addr)
        cmg_pkg::ADDR_CTRL: begin
          st_next.rdata = st_reg.ctrl & cmg_pkg::CTRL_WMASK;
          st_next.rdata[cmg_pkg::CTRL_EVT] = st_reg.evt;
          st_next.rdata[cmg_pkg::CTRL_OUT] = adj_prev;
        end
        cmg_pkg::ADDR_MASK: st_next.rdata = {12'h000, st_reg.gate};
        cmg_pkg::ADDR_IRQ_STAT: st_next.rdata = {14'h0000, st_reg.stat};
        cmg_pkg::ADDR_IRQ_MASK: st_next.rdata = {14'h0000, st_reg.irq_mask};
        default: st_next.rdata = 16'h0000;
      endcase
    end
    if (i_wr) begin
      unique case (i_addr)
        cmg_pkg::ADDR_CTRL: begin
          st_next.ctrl = i_wdata & cmg_pkg::CTRL_WMASK;
          if (!i_wdata[cmg_pkg::CTRL_EVT]) begin
            st_next.evt = 1'b0;
          end
        end
        cmg_pkg::ADDR_MASK: st_next.gate = i_wdata[3:0];
        cmg_pkg::ADDR_IRQ_STAT: st_next.stat = st_reg.stat & ~i_wdata[1:0];
        cmg_pkg::ADDR_IRQ_MASK: st_next.irq_mask = i_wdata[1:0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    if (edge_hit) begin
      st_next.evt = 1'b1;
      st_next.stat[0] = 1'b1;
    end
    st_next.pos_ref = st_next.ctrl[cmg_pkg::CTRL_POS_SEL];
    unique case (st_next.ctrl[cmg_pkg::CTRL_NEG_HI:cmg_pkg::CTRL_NEG_LO])
      2'h3: st_next.neg_sel = 4'h8;
      2'h2: st_next.neg_sel = 4'h4;
      2'h1: st_next.neg_sel = 4'h2;
      2'h0: st_next.neg_sel = 4'h1;
    endcase
    st_next.amp_en = st_next.ctrl[cmg_pkg::CTRL_AMP_EN];
    st_next.and_out = (i_mask_input_b | ~st_reg.gate[3])
                    & (~i_mask_input_b | ~st_reg.gate[2])
                    & (i_mask_input_a | ~st_reg.gate[1])
                    & (~i_mask_input_a | ~st_reg.gate[0]);
    // Gate rise flag, computed after the next AND gate output is known
    if (st_reg.and_out == 1'b0 && st_next.and_out == 1'b1) begin
      st_next.stat[1] = 1'b1;
    end
    st_next.irq = |(st_next.stat & st_next.irq_mask);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '{ctrl: cmg_pkg::CTRL_RESET, gate: cmg_pkg::MASK_RESET,
                 stat: cmg_pkg::IRQ_RESET, irq_mask: cmg_pkg::IRQ_RESET,
                 neg_sel: 4'h1, and_out: 1'b1, default: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_negative_input_select = st_reg.neg_sel;
  assign o_positive_input_select = st_reg.pos_ref;
  assign o_amplifier_enable = st_reg.amp_en;
  assign o_and_gate_out = st_reg.and_out;
  assign o_event_pulse_level = st_reg.evt;
  assign o_irq = st_reg.irq;

  // Assertions
  a_any_edge_sets: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (st_reg.ctrl[7:6] == 2'h3 && !st_reg.evt
     && (i_comparator_result != st_reg.cmp_prev)) |=> st_reg.evt)
    else $error("any-change edge missed");

  a_fall_edge_sets: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (st_reg.ctrl[7:6] == 2'h2 && !st_reg.evt && adj_prev && !adj_now)
    |=> st_reg.evt)
    else $error("falling edge missed");

  a_rise_edge_sets: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (st_reg.ctrl[7:6] == 2'h1 && !st_reg.evt && !adj_prev && adj_now)
    |=> st_reg.evt)
    else $error("rising edge missed");

  a_evt_blocks: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    st_reg.evt |-> !edge_hit)
    else $error("edge taken while flag set");

  a_mode_off: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (st_reg.ctrl[7:6] == 2'h0) |-> !edge_hit)
    else $error("event while disabled");

  a_pos_route: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    ##1 o_positive_input_select == $past(st_next.ctrl[4]))
    else $error("positive select wrong");

  a_neg_onehot: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    ##1 o_negative_input_select == (4'h1 << $past(st_next.ctrl[1:0])))
    else $error("negative select wrong");

  a_rsvd_zero: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == 4'h0
    |-> o_rdata[5] == 1'b0 && o_rdata[3:2] == 2'h0)
    else $error("reserved bits nonzero");

  a_and_gate: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    st_reg.gate == 4'hA |=> o_and_gate_out
    == ($past(i_mask_input_a) & $past(i_mask_input_b)))
    else $error("AND gate wrong");

  a_flag_sticky: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    st_reg.stat[0] && !(i_wr && i_addr == 4'h2 && i_wdata[0])
    |=> st_reg.stat[0])
    else $error("flag dropped");

  a_evt_hold: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    st_reg.evt && !(i_wr && i_addr == 4'h0 && !i_wdata[9])
    |=> st_reg.evt)
    else $error("event flag dropped");

  a_evt_clear: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_wr && i_addr == 4'h0 && !i_wdata[9] && !edge_hit
    |=> !st_reg.evt)
    else $error("event flag not cleared");

  a_evt_from_edge: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $rose(st_reg.evt) |-> $past(edge_hit))
    else $error("event flag set without edge");

  a_stat_from_edge: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $rose(st_reg.stat[0]) |-> $past(edge_hit))
    else $error("status set without edge");

  a_hit_sets_both: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    edge_hit |=> st_reg.evt && st_reg.stat[0])
    else $error("edge did not set both flags");

  a_stat_clear: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_wr && i_addr == 4'h2 && i_wdata[0] && !edge_hit
    |=> !st_reg.stat[0])
    else $error("status not cleared");

  a_ctrl_write: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_wr && i_addr == 4'h0
    |=> st_reg.ctrl == ($past(i_wdata) & cmg_pkg::CTRL_WMASK))
    else $error("control write wrong");

  a_gate_write: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_wr && i_addr == 4'h1 |=> st_reg.gate == $past(i_wdata[3:0]))
    else $error("gating write wrong");

  a_mask_write: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_wr && i_addr == 4'h3 |=> st_reg.irq_mask == $past(i_wdata[1:0]))
    else $error("mask write wrong");

  a_amp_follow: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    ##1 o_amplifier_enable == $past(st_next.ctrl[10]))
    else $error("amplifier enable wrong");

  a_neg_hot: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $onehot(o_negative_input_select))
    else $error("negative select not one-hot");

  a_and_all_off: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    st_reg.gate == 4'h0 |=> o_and_gate_out)
    else $error("empty gate not high");

  a_b_true: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    st_reg.gate[3] && !i_mask_input_b |=> !o_and_gate_out)
    else $error("gate B true term ignored");

  a_b_inv: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    st_reg.gate[2] && i_mask_input_b |=> !o_and_gate_out)
    else $error("gate B inverted term ignored");

  a_a_true: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    st_reg.gate[1] && !i_mask_input_a |=> !o_and_gate_out)
    else $error("gate A true term ignored");

  a_a_inv: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    st_reg.gate[0] && i_mask_input_a |=> !o_and_gate_out)
    else $error("gate A inverted term ignored");

  a_ctrl_rsvd: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    st_reg.ctrl[5] == 1'b0 && st_reg.ctrl[3:2] == 2'h0)
    else $error("reserved control bits stored");

  a_rd_ctrl_evt: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == 4'h0
    |-> o_rdata[9] == $past(st_reg.evt))
    else $error("event flag read wrong");

  a_rd_ctrl_out: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == 4'h0
    |-> o_rdata[8] == $past(adj_prev))
    else $error("result bit read wrong");

  a_rd_hi_zero: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == 4'h0
    |-> o_rdata[15:14] == 2'h0 && o_rdata[12:11] == 2'h0)
    else $error("upper control bits nonzero");

  a_rd_gate: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == 4'h1
    |-> o_rdata == {12'h000, $past(st_reg.gate)})
    else $error("gating read wrong");

  a_rd_stat: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == 4'h2
    |-> o_rdata == {14'h0000, $past(st_reg.stat)})
    else $error("status read wrong");

  a_rd_mask: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == 4'h3
    |-> o_rdata == {14'h0000, $past(st_reg.irq_mask)})
    else $error("mask read wrong");

  a_rd_unmapped: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) > 4'h3 |-> o_rdata == 16'h0000)
    else $error("unmapped read nonzero");

  a_rd_idle: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    !$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read");

  a_irq_match: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    o_irq == |(st_reg.stat & st_reg.irq_mask))
    else $error("interrupt level wrong");

  a_and_rise_stat: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $rose(st_reg.and_out) |-> st_reg.stat[1])
    else $error("gate rise not flagged");

  a_stat1_cause: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $rose(st_reg.stat[1]) |-> $rose(st_reg.and_out))
    else $error("gate flag without rise");

  c_any: cover property (@(posedge i_ref_clk) st_reg.ctrl[7:6] == 2'h3
    && edge_hit);

  c_fall: cover property (@(posedge i_ref_clk) st_reg.ctrl[7:6] == 2'h2
    && edge_hit);

  c_rise: cover property (@(posedge i_ref_clk) st_reg.ctrl[7:6] == 2'h1
    && edge_hit);

  c_and_rise: cover property (@(posedge i_ref_clk) $rose(st_reg.and_out));

  c_irq: cover property (@(posedge i_ref_clk) o_irq);
endmodule // cmg_core
`default_nettype wire

// ===== test/cmg_src_model.sv
// Model of the comparator result and the two mask sources
`timescale 1ns/100ps
`default_nettype none
module cmg_src_model (
  input wire logic i_ref_clk,
  input wire logic [2:0] i_cmd,
  output logic [2:0] o_src
);
  always_ff @(posedge i_ref_clk) o_src <= i_cmd;
endmodule // cmg_src_model
`default_nettype wire

// ===== test/cmg_core_tb.sv
// Self-checking bench for the comparator event and mask gating block
`timescale 1ns/100ps
`default_nettype none
module cmg_core_tb;
  localparam logic [3:0] AC = cmg_pkg::ADDR_CTRL, AS = cmg_pkg::ADDR_IRQ_STAT;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, pos, amp, andq, evt, irq;
  logic [3:0] addr = 4'h0, neg;
  logic [15:0] wdat = 16'h0000, rdat, d;
  logic [2:0] cmd = 3'h0, src;
  wire [15:0] pins = {7'h00, andq, amp, pos, neg, irq, evt};
  int n_fail = 0, checked = 0, e;
  cmg_src_model cmg_src_model_inst (.i_ref_clk(clk), .i_cmd(cmd),
    .o_src(src));
  cmg_core cmg_core_inst (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdat), .i_wr(wr), .i_rd(rd), .i_comparator_result(src[2]),
    .i_mask_input_a(src[0]), .i_mask_input_b(src[1]), .o_rdata(rdat),
    .o_negative_input_select(neg), .o_positive_input_select(pos),
    .o_amplifier_enable(amp), .o_and_gate_out(andq),
    .o_event_pulse_level(evt), .o_irq(irq));
  initial forever #10 clk = ~clk;
  task automatic bus(input logic w, logic [3:0] a, logic [15:0] v);
    @(posedge clk);
    {addr, wdat} <= {a, v};
    {wr, rd} <= {w, !w};
    @(posedge clk);
    {wr, rd} <= 2'h0;
    #1 d = rdat;
  endtask
  task automatic drv(input logic [2:0] v, int n);
    @(posedge clk);
    cmd <= v;
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, logic [15:0] x, g);
    checked++;
    n_fail += int'(g !== x);
    if (g !== x) $display("ERROR %s exp %h got %h", nm, x, g);
  endtask
  task automatic test_done();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_sel();
    bus(1'h0, AC, 16'h0000);
    chk("ctl", cmg_pkg::CTRL_RESET, d);
    chk("pin", 16'h0104, pins);
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, AC, 16'(16'h042C + i % 2 * 16 + i));
      bus(1'h0, AC, 16'h0000);
      chk("ctl", 16'(16'h0400 + i % 2 * 16 + i), d);
      chk("pin", 16'(16'h0180 + i % 2 * 64 + (4 << i)), pins);
    end
    bus(1'h0, 4'h7, 16'h0000);
    chk("rsv", 16'h0000, d);
  endtask
  task automatic t_edge();
    for (int k = 0; k < 16; k++) begin
      drv({k[0], 2'h0}, 2);
      bus(1'h1, AC, 16'(k[1] * 16'h2000 + k / 4 * 64 + 16'h0400));
      bus(1'h1, AS, 16'h0003);
      bus(1'h1, cmg_pkg::ADDR_IRQ_MASK, 16'(k % 3 != 0));
      drv({!k[0], 2'h0}, 4);
      e = (k > 11 || k > 3 && (k < 8) == (k[0] == k[1])) * (k % 3 ? 3 : 1);
      chk("evt", 16'(e), pins & 16'h0003);
      if (e != 0) begin
        bus(1'h1, AS, 16'h0001);
        drv({k[0], 2'h0}, 4);
        chk("hold", 16'h0001, pins & 16'h0003);
      end
    end
  endtask
  task automatic t_gate();
    for (int k = 0; k < 64; k++) begin
      if (k % 4 == 0) bus(1'h1, cmg_pkg::ADDR_MASK, 16'(k / 4));
      drv({cmd[2], k[1], k[0]}, 3);
      e = !(k[5:2] & ~{k[1], !k[1], k[0], !k[0]});
      chk("and", 16'(e), 16'(andq));
    end
    bus(1'h0, AS, 16'h0000);
    chk("grise", 16'h0002, d & 16'h0002);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_sel();
    t_edge();
    t_gate();
    test_done();
  end
endmodule // cmg_core_tb
`default_nettype wire
